// ---- core/srs_params.svh ----
`ifndef SRS_PARAMS_SVH
`define SRS_PARAMS_SVH
`define SRS_CLK_MHZ 250
`define SRS_POR_SETTLE_US 10
`define SRS_BOR_SETTLE_US 10
`define SRS_POR_SETTLE_CYC ((`SRS_POR_SETTLE_US * `SRS_CLK_MHZ) > 0 ? (`SRS_POR_SETTLE_US * `SRS_CLK_MHZ) : 1)
`define SRS_BOR_SETTLE_CYC ((`SRS_BOR_SETTLE_US * `SRS_CLK_MHZ) > 0 ? (`SRS_BOR_SETTLE_US * `SRS_CLK_MHZ) : 1)
`define SRS_CYC_PER_MS (`SRS_CLK_MHZ * 1000)
`define SRS_POWERUP_TIMER_MS0 0
`define SRS_POWERUP_TIMER_MS1 2
`define SRS_POWERUP_TIMER_MS2 4
`define SRS_POWERUP_TIMER_MS3 8
`define SRS_POWERUP_TIMER_MS4 16
`define SRS_POWERUP_TIMER_MS5 32
`define SRS_POWERUP_TIMER_MS6 64
`define SRS_POWERUP_TIMER_MS7 128
`define SRS_CAUSE_POR_BIT 0
`define SRS_CAUSE_BOR_BIT 1
`define SRS_CAUSE_RESET 2'h0
`define SRS_SEL_RESET 3'h7
`endif

// ---- core/srs_pkg.sv ----
package srs_pkg;
	typedef enum logic [1:0] {
		SRS_POR_WAIT = 2'b00,
		SRS_SETTLE   = 2'b01,
		SRS_POWERUP_TIMER     = 2'b10,
		SRS_RUN      = 2'b11
	} srs_state_t;
	typedef logic [31:0] srs_count_t;
endpackage

// ---- core/srs_sync.sv ----
// three-stage synchroniser; change accepted once stages two and three agree
module srs_sync (
	input  wire logic clk,
	input  wire logic resetn,
	input  wire logic clkEn,
	input  wire logic resetVal,
	input  wire logic asyncIn,
	output logic      syncOut
);
	logic s1Q;
	logic s2Q;
	logic s3Q;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s1Q <= 1'b0;
			s2Q <= 1'b0;
			s3Q <= 1'b0;
		end else if (clkEn) begin
			s1Q <= asyncIn;
			s2Q <= s1Q;
			s3Q <= s2Q;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			syncOut <= 1'b0;
		end else if (clkEn && (s2Q == s3Q)) begin
			syncOut <= s3Q;
		end
	end

	// resetVal kept for symmetry of instances; not used
	logic unusedQ;
	assign unusedQ = resetVal;
endmodule

// ---- core/supply_reset_sequencer.sv ----
`include "srs_params.svh"
module supply_reset_sequencer
	import srs_pkg::*;
#(
	parameter srs_count_t PorSettleCyc = `SRS_POR_SETTLE_CYC,
	parameter srs_count_t BorSettleCyc = `SRS_BOR_SETTLE_CYC,
	parameter srs_count_t CycPerMs     = `SRS_CYC_PER_MS
) (
	input  wire logic       clk,
	input  wire logic       resetn,
	input  wire logic       clkEn,
	input  wire logic       poweronAbove,
	input  wire logic       brownoutAbove,
	input  wire logic [2:0] powerupDelaySelect,
	input  wire logic [1:0] causeClearWr,
	output logic            systemResetOut,
	output logic [1:0]      resetCause
);
	srs_state_t stateQ;
	srs_count_t cntQ;
	logic       porOk;
	logic       borOk;
	logic       borOkQ;
	logic [2:0] selQ;

	// delay table in ms, outer codes fixed at 0 and 128
	function automatic srs_count_t pwrtMs(input logic [2:0] sel);
		case (sel)
			3'h0: pwrtMs = `SRS_POWERUP_TIMER_MS0;
			3'h1: pwrtMs = `SRS_POWERUP_TIMER_MS1;
			3'h2: pwrtMs = `SRS_POWERUP_TIMER_MS2;
			3'h3: pwrtMs = `SRS_POWERUP_TIMER_MS3;
			3'h4: pwrtMs = `SRS_POWERUP_TIMER_MS4;
			3'h5: pwrtMs = `SRS_POWERUP_TIMER_MS5;
			3'h6: pwrtMs = `SRS_POWERUP_TIMER_MS6;
			default: pwrtMs = `SRS_POWERUP_TIMER_MS7;
		endcase
	endfunction

	srs_sync uPorSync (
		.clk     (clk),
		.resetn  (resetn),
		.clkEn   (clkEn),
		.resetVal(1'b0),
		.asyncIn (poweronAbove),
		.syncOut (porOk)
	);

	srs_sync uBorSync (
		.clk     (clk),
		.resetn  (resetn),
		.clkEn   (clkEn),
		.resetVal(1'b0),
		.asyncIn (brownoutAbove),
		.syncOut (borOk)
	);

	// delayed copy finds each rise of the brown-out level
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			borOkQ <= 1'b0;
		end else if (clkEn) begin
			borOkQ <= borOk;
		end
	end

	// sequencer: por wait, power-up timer, run; settle only after a brown-out, then power-up timer
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			stateQ <= SRS_POR_WAIT;
			cntQ   <= '0;
			selQ   <= `SRS_SEL_RESET;
		end else if (clkEn) begin
			if (!porOk) begin
				stateQ <= SRS_POR_WAIT;
				cntQ   <= '0;
			end else if (!borOk && stateQ != SRS_POR_WAIT) begin
				stateQ <= SRS_SETTLE;
				cntQ   <= '0;
			end else if (borOk && !borOkQ && stateQ != SRS_POR_WAIT) begin
				stateQ <= SRS_SETTLE;
				cntQ   <= '0;
			end else begin
				case (stateQ)
					SRS_POR_WAIT: begin
						if (cntQ >= PorSettleCyc - 1) begin
							stateQ <= SRS_POWERUP_TIMER;
							cntQ   <= '0;
							selQ   <= powerupDelaySelect;
						end else begin
							cntQ <= cntQ + 1;
						end
					end
					SRS_SETTLE: begin
						if (!borOk) begin
							cntQ <= '0;
						end else if (cntQ >= BorSettleCyc - 1) begin
							stateQ <= SRS_POWERUP_TIMER;
							cntQ   <= '0;
							selQ   <= powerupDelaySelect;
						end else begin
							cntQ <= cntQ + 1;
						end
					end
					SRS_POWERUP_TIMER: begin
						if (cntQ >= pwrtMs(selQ) * CycPerMs) begin
							stateQ <= SRS_RUN;
						end else begin
							cntQ <= cntQ + 1;
						end
					end
					SRS_RUN: begin
						cntQ <= '0;
					end
					default: begin
						stateQ <= SRS_POR_WAIT;
						cntQ   <= '0;
					end
				endcase
			end
		end
	end

	// reset output is registered so it cannot glitch
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			systemResetOut <= 1'b1;
		end else if (clkEn) begin
			systemResetOut <= (stateQ != SRS_RUN) || !porOk || !borOk;
		end
	end

	// cause flags: set wins over software clear
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			resetCause <= `SRS_CAUSE_RESET;
		end else if (clkEn) begin
			if (!porOk) begin
				resetCause[`SRS_CAUSE_POR_BIT] <= 1'b1;
			end else if (causeClearWr[`SRS_CAUSE_POR_BIT]) begin
				resetCause[`SRS_CAUSE_POR_BIT] <= 1'b0;
			end
			if (porOk && !borOk) begin
				resetCause[`SRS_CAUSE_BOR_BIT] <= 1'b1;
			end else if (causeClearWr[`SRS_CAUSE_BOR_BIT]) begin
				resetCause[`SRS_CAUSE_BOR_BIT] <= 1'b0;
			end
		end
	end

	a_bor_forces_rst: assert property (@(posedge clk) disable iff (!resetn)
		(clkEn && porOk && !borOk) |=> systemResetOut)
		else $error("brown-out did not hold reset");
	a_por_holds_rst: assert property (@(posedge clk) disable iff (!resetn)
		(clkEn && !porOk) |=> systemResetOut)
		else $error("power-on reset not held");
	a_release_after_timer: assert property (@(posedge clk) disable iff (!resetn)
		$fell(systemResetOut) |-> $past(stateQ) == SRS_RUN)
		else $error("reset released before timer");
	a_bor_flag_set: assert property (@(posedge clk) disable iff (!resetn)
		(clkEn && porOk && !borOk) |=> resetCause[1])
		else $error("brown-out flag not set");
	a_por_flag_set: assert property (@(posedge clk) disable iff (!resetn)
		(clkEn && !porOk) |=> resetCause[0])
		else $error("power-on flag not set");
	a_flag_sticky: assert property (@(posedge clk) disable iff (!resetn)
		(resetCause[0] && !causeClearWr[0]) |=> resetCause[0])
		else $error("cause flag dropped without clear");
	a_rise_restarts: assert property (@(posedge clk) disable iff (!resetn)
		(clkEn && porOk && borOk && !borOkQ && stateQ != SRS_POR_WAIT)
		|=> (stateQ == SRS_SETTLE && cntQ == 0))
		else $error("rise did not restart delay");
	a_settle_counts: assert property (@(posedge clk) disable iff (!resetn)
		(stateQ == SRS_SETTLE) |=> stateQ != SRS_RUN)
		else $error("settle skipped power-up timer");

	// sequencing checks
	a_bor_enters_settle: assert property (@(posedge clk) disable iff (!resetn)
		(clkEn && porOk && !borOk && stateQ != SRS_POR_WAIT) |=> stateQ == SRS_SETTLE)
		else $error("brown-out did not restart settle");
	a_por_to_timer: assert property (@(posedge clk) disable iff (!resetn)
		(stateQ == SRS_POR_WAIT) |=> (stateQ == SRS_POR_WAIT || stateQ == SRS_POWERUP_TIMER))
		else $error("power-on wait left to wrong state");
	a_run_from_timer: assert property (@(posedge clk) disable iff (!resetn)
		($changed(stateQ) && stateQ == SRS_RUN) |-> $past(stateQ) == SRS_POWERUP_TIMER)
		else $error("run entered without power-up timer");
	a_timer_not_short: assert property (@(posedge clk) disable iff (!resetn)
		(clkEn && porOk && borOk && borOkQ && stateQ == SRS_POWERUP_TIMER
			&& cntQ < pwrtMs(selQ) * CycPerMs) |=> stateQ != SRS_RUN)
		else $error("power-up timer ended early");
	a_sel_held: assert property (@(posedge clk) disable iff (!resetn)
		(stateQ == SRS_POWERUP_TIMER && $past(stateQ) == SRS_POWERUP_TIMER) |-> $stable(selQ))
		else $error("delay select changed during timer");

	// cause flag checks
	a_bor_clear: assert property (@(posedge clk) disable iff (!resetn)
		(clkEn && porOk && borOk && causeClearWr[1]) |=> !resetCause[1])
		else $error("brown-out flag not cleared");
	a_por_clear: assert property (@(posedge clk) disable iff (!resetn)
		(clkEn && porOk && causeClearWr[0]) |=> !resetCause[0])
		else $error("power-on flag not cleared");
	a_en_freezes: assert property (@(posedge clk) disable iff (!resetn)
		!clkEn |=> ($stable(resetCause) && $stable(systemResetOut)))
		else $error("state moved while clock enable low");

	// scenarios worth seeing
	c_release: cover property (@(posedge clk) disable iff (!resetn) $fell(systemResetOut));
	c_brownout: cover property (@(posedge clk) disable iff (!resetn) $rose(resetCause[1]));
	c_restart: cover property (@(posedge clk) disable iff (!resetn)
		stateQ == SRS_POWERUP_TIMER ##1 stateQ == SRS_SETTLE);
	c_freeze: cover property (@(posedge clk) disable iff (!resetn) !clkEn ##1 clkEn);
	c_bor_clear: cover property (@(posedge clk) disable iff (!resetn) $fell(resetCause[1]));
endmodule

// ---- bench/srs_supply_model.sv ----
module srs_supply_model (
	input  wire logic [1:0] supplyLevel,
	output logic            poweronAbove,
	output logic            brownoutAbove
);
	timeunit 1ns;
	timeprecision 100ps;
	// level 0 below both trips, 1 between them, 2 above both
	assign poweronAbove  = supplyLevel >= 2'h1;
	assign brownoutAbove = supplyLevel >= 2'h2;
endmodule

// ---- bench/tb.sv ----
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct {int lo; logic [1:0] c;} srs_note_t;
	logic       clk, resetn, clkEn, pa, ba, sro;
	logic [1:0] lvl, clr, cause;
	logic [2:0] sel;
	int         n_fail, compares, cyc, tRise, nDone, rs;
	int         seed = 32'h1bb2e89e;
	srs_note_t  q[$];
	srs_supply_model u_sup (.supplyLevel(lvl), .poweronAbove(pa), .brownoutAbove(ba));
	supply_reset_sequencer #(.PorSettleCyc(32'h4), .BorSettleCyc(32'h4), .CycPerMs(32'h2)) u_dut (
		.clk(clk), .resetn(resetn), .clkEn(clkEn), .poweronAbove(pa), .brownoutAbove(ba),
		.powerupDelaySelect(sel), .causeClearWr(clr), .systemResetOut(sro), .resetCause(cause));
	initial begin
		clk = 0;
		forever #2 clk = ~clk;
	end
	function automatic int ms(int i);
		return (i == 0) ? 0 : (1 << i);
	endfunction
	task chk(string nm, logic [31:0] seen, logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask
	task results;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task step(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task await(int k);
		int i;
		i = 0;
		while (nDone < k && i < 3000) begin
			step(1);
			i++;
		end
		if (nDone < k) begin
			n_fail++;
			results();
		end
	endtask
	// raise supply above both trips and note the shortest legal hold
	task rise(int s, logic [1:0] c);
		srs_note_t nt;
		sel = s[2:0];
		lvl = 2'h2;
		tRise = cyc;
		nt.lo = 4 + ms(s) * 2;
		nt.c = c;
		q.push_back(nt);
	endtask
	// watches each release of system reset against the oldest note
	initial begin
		srs_note_t nt;
		logic      prev;
		prev = 1'b1;
		forever begin
			// falling edge, so registered outputs have settled
			@(negedge clk);
			cyc++;
			if (q.size() > 0 && prev === 1'b1 && sro === 1'b0) begin
				nt = q.pop_front();
				chk("holdMin", 32'((cyc - tRise) >= nt.lo), 32'h1);
				chk("holdMax", 32'((cyc - tRise) <= nt.lo + 16), 32'h1);
				chk("causeAtRelease", 32'(cause), 32'(nt.c));
				nDone++;
			end
			prev = sro;
		end
	end
	initial begin
		clkEn = 1'b1;
		lvl = 2'h0;
		sel = 3'h7;
		clr = 2'h0;
		resetn = 1'b0;
		step(4);
		resetn = 1'b1;
		for (int s = 0; s < 8; s++) begin
			if (s > 0) begin
				resetn = 1'b0;
				lvl = 2'h0;
				step(2);
				resetn = 1'b1;
			end
			step(6);
			chk("porHold", 32'(sro), 32'h1);
			rise(s, 2'h1);
			await(s + 1);
		end
		$display("test power-up codes done");
		clr = 2'h1;
		step(1);
		clr = 2'h0;
		step(1);
		chk("clearPor", 32'(cause), 32'h0);
		lvl = 2'h1;
		step(10);
		chk("bodReset", 32'(sro), 32'h1);
		chk("bodCause", 32'(cause), 32'h2);
		lvl = 2'h2;
		step(6);
		lvl = 2'h1;
		step(8);
		chk("bounceHold", 32'(sro), 32'h1);
		rs = $random(seed) & 7;
		rise(rs, 2'h2);
		await(9);
		step(20);
		chk("causeSticky", 32'(cause), 32'h2);
		clkEn = 1'b0;
		clr = 2'h2;
		step(3);
		chk("freezeCause", 32'(cause), 32'h2);
		chk("freezeReset", 32'(sro), 32'h0);
		clkEn = 1'b1;
		step(1);
		clr = 2'h0;
		step(1);
		chk("clearBor", 32'(cause), 32'h0);
		lvl = 2'h1;
		clr = 2'h2;
		step(10);
		chk("setWins", 32'(cause), 32'h2);
		chk("bodAgain", 32'(sro), 32'h1);
		clr = 2'h0;
		$display("test brown-out done");
		results();
	end
endmodule
